// >>> hw/aios_pkg.sv
package aios_pkg;

  // Clock and filter update tick
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FILT_TICK_US = 10000;
  localparam int unsigned FILT_TICK_CYC = (CLK_HZ / 1000000) * FILT_TICK_US;
  localparam int unsigned FILT_FRAC = 8;

  // Register byte offsets
  localparam logic [5:0] OFS_AIN_VALUE = 6'h00;
  localparam logic [5:0] OFS_DEAD_ZONE_SEL = 6'h04;
  localparam logic [5:0] OFS_AIN_FUNCTION = 6'h08;
  localparam logic [5:0] OFS_AIN_GAIN = 6'h0C;
  localparam logic [5:0] OFS_AIN_SIGNAL_TYPE = 6'h10;
  localparam logic [5:0] OFS_AIN_OFFSET = 6'h14;
  localparam logic [5:0] OFS_AIN_FILTER_TC = 6'h18;
  localparam logic [5:0] OFS_TEMP_READING = 6'h1C;
  localparam logic [5:0] OFS_AOUT_VALUE = 6'h20;
  localparam logic [5:0] OFS_AOUT_FUNCTION = 6'h24;
  localparam logic [5:0] OFS_AOUT_GAIN = 6'h28;
  localparam logic [5:0] OFS_MIN_FREQUENCY = 6'h2C;
  localparam logic [5:0] OFS_MAX_FREQUENCY = 6'h30;
  localparam logic [5:0] OFS_FREQ_REF = 6'h34;
  localparam logic [5:0] OFS_STATUS = 6'h38;

  // Status bit positions
  localparam int unsigned ST_RANGE_SW = 0;
  localparam int unsigned ST_NTC_OPEN = 1;
  localparam int unsigned ST_NTC_SHORT = 2;
  localparam int unsigned ST_REVERSE = 3;

  // Reset values
  localparam logic [15:0] RST_DEAD_ZONE_SEL = 16'h0000;
  localparam logic [15:0] RST_AIN_FUNCTION = 16'h0000;
  localparam logic [15:0] RST_AIN_GAIN = 16'h03E8;
  localparam logic [15:0] RST_AIN_SIGNAL_TYPE = 16'h0000;
  localparam logic [15:0] RST_AIN_OFFSET = 16'h0000;
  localparam logic [15:0] RST_AIN_FILTER_TC = 16'h0000;
  localparam logic [15:0] RST_AOUT_FUNCTION = 16'h0000;
  localparam logic [15:0] RST_AOUT_GAIN = 16'h03E8;
  localparam logic [15:0] RST_MIN_FREQUENCY = 16'h001E;
  localparam logic [15:0] RST_MAX_FREQUENCY = 16'h0258;

  // Scaling: percent in 0.1 %, gain in 0.001, filter in 0.01 s
  localparam int PCT_FULL = 1000;
  localparam int GAIN_UNIT = 1000;
  localparam int GAIN_MAX = 9999;
  localparam int FILT_TC_MAX = 1600;
  localparam int ADC_FULL = 4095;
  localparam int ADC_LIVE_ZERO = 819;
  localparam int ADC_LIVE_SPAN = 3276;

  // Signal types and functions
  localparam logic [1:0] SIG_DIRECT = 2'h0;
  localparam logic [1:0] SIG_LIVE_ZERO = 2'h1;
  localparam logic [1:0] SIG_INV_DIRECT = 2'h2;
  localparam logic [1:0] SIG_INV_LIVE_ZERO = 2'h3;
  localparam logic [15:0] AIN_FN_FREQ_REF = 16'h0000;
  localparam logic [15:0] AIN_FN_USER = 16'h0007;
  localparam logic [15:0] AIN_FN_MAX = 16'h0007;
  localparam logic [15:0] AO_FN_SPEED_REF = 16'h0000;
  localparam logic [15:0] AO_FN_EFF_SPEED = 16'h0002;
  localparam logic [15:0] AO_FN_OUT_CURRENT = 16'h0005;
  localparam logic [15:0] AO_FN_ACT_CURRENT = 16'h0007;
  localparam logic [15:0] AO_FN_TORQUE = 16'h000B;
  localparam logic [15:0] AO_FN_USER = 16'h000C;
  localparam logic [15:0] AO_FN_IXT = 16'h0010;

  // Temperature reading
  localparam logic [15:0] TEMP_OPEN_VAL = 16'h03E7;
  localparam logic [15:0] TEMP_SHORT_VAL = 16'h0000;
  localparam logic [15:0] TEMP_MAX_VAL = 16'h0064;

endpackage

// >>> hw/aios_top.sv
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Input path is normalise, add offset, multiply gain, filter, then route.
// - Input value register reports offset and gain result as signed percent.
// - Input gain 0.000 to 9.999, default 1.000, multiplies corrected percent.
// - Input offset -100.0 to 100.0 percent, default 0, added before gain.
// - Filter setting 0.00 to 16.00 s is a low-pass time constant.
// - Filter step response settles after about three time constants.
// - Signal types 2 and 3 invert: result is 100 percent minus scaled value.
// - Live-zero current subtracts 4 mA and divides by a 16 mA span.
// - Range select switch makes the first analog input a current input.
// - Dead zone applies only to frequency reference; 1 enables, 0 disables.
// - Dead zone off: minimum input maps straight to minimum frequency.
// - Dead zone on: reference holds minimum frequency over a low input band.
// - Function 0 gives frequency reference limited by min and max frequency.
// - Function 7 feeds user logic; functions 1 to 6 leave input unused.
// - Temperature reading is read-only, 0 to 100 degrees Celsius.
// - Open sensor reads 999 degrees; shorted sensor reads 0 degrees.
// - Output value 0.0 to 100.0 percent after multiplying by output gain.
// - Output selector codes 0,2,5,7,11,12,16 pick the driven quantity.
// - Negative reference commands reverse, frequency mapped from its magnitude as for a positive one.
module aios_top #(
  parameter int unsigned TICK_CYCLES = aios_pkg::FILT_TICK_CYC,
  parameter int ADC_W = 12
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [ADC_W-1:0] ain_sample,
  input wire logic ain_sample_valid,
  input wire logic range_select_switch,
  input wire logic [9:0] temp_sample,
  input wire logic ntc_open,
  input wire logic ntc_short,
  input wire logic [15:0] src_speed_ref,
  input wire logic [15:0] src_eff_speed,
  input wire logic [15:0] src_out_current,
  input wire logic [15:0] src_act_current,
  input wire logic [15:0] src_torque,
  input wire logic [15:0] src_user,
  input wire logic [15:0] src_ixt,
  output logic [15:0] freq_ref,
  output logic freq_reverse,
  output logic freq_ref_active,
  output logic [15:0] ain_user,
  output logic [15:0] aout_level
);

  logic [1:0] sw_sync_r;
  logic [1:0] open_sync_r;
  logic [1:0] short_sync_r;
  logic [ADC_W-1:0] sample_r;
  logic sample_new_r;
  logic [15:0] dead_zone_sel_r;
  logic [15:0] ain_function_r;
  logic [15:0] ain_gain_r;
  logic [15:0] ain_signal_type_r;
  logic [15:0] ain_offset_r;
  logic [15:0] ain_filter_tc_r;
  logic [15:0] aout_function_r;
  logic [15:0] aout_gain_r;
  logic [15:0] min_frequency_r;
  logic [15:0] max_frequency_r;
  logic [15:0] ain_value_r;
  logic [15:0] temp_reading_r;
  logic signed [31:0] filt_acc_r;
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] freq_ref_r;
  logic freq_reverse_r;
  logic freq_ref_active_r;
  logic [15:0] ain_user_r;
  logic [15:0] aout_level_r;
  logic [31:0] readdata_r;
  logic waitrequest_r;
  logic [15:0] ain_value_nxt;
  logic signed [31:0] filt_acc_nxt;
  logic [15:0] freq_ref_nxt;
  logic [15:0] aout_level_nxt;
  logic [31:0] rd_nxt;
  logic signed [15:0] filt_pct;
  logic [15:0] status;
  logic wr_take;

  function automatic int sat(input int v, input int lo, input int hi);
    sat = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Pins from outside: two flops before use
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sw_sync_r <= 2'h0;
      open_sync_r <= 2'h0;
      short_sync_r <= 2'h0;
    end
    else
    begin
      sw_sync_r <= {sw_sync_r[0], range_select_switch};
      open_sync_r <= {open_sync_r[0], ntc_open};
      short_sync_r <= {short_sync_r[0], ntc_short};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      sample_r <= '0;
      sample_new_r <= 1'b0;
    end
    else
    begin
      sample_new_r <= ain_sample_valid;
      if (ain_sample_valid)
        sample_r <= ain_sample;
    end
  end

  // Normalise, offset, gain, invert, saturate
  always_comb
  begin
    int raw;
    int norm;
    int scaled;
    logic live;
    norm = 0;
    raw = int'(sample_r);
    live = ain_signal_type_r[0] && sw_sync_r[1];
    if (live)
    begin
      norm = ((raw - aios_pkg::ADC_LIVE_ZERO) * aios_pkg::PCT_FULL)
        / aios_pkg::ADC_LIVE_SPAN;
    end
    else
    begin
      norm = (raw * aios_pkg::PCT_FULL) / aios_pkg::ADC_FULL;
    end
    scaled = norm + int'($signed(ain_offset_r));
    scaled = (scaled * int'(ain_gain_r)) / aios_pkg::GAIN_UNIT;
    if (ain_signal_type_r[1])
      scaled = aios_pkg::PCT_FULL - scaled;
    ain_value_nxt = 16'(sat(scaled, -aios_pkg::PCT_FULL, aios_pkg::PCT_FULL));
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      ain_value_r <= 16'h0000;
    else if (sample_new_r)
      ain_value_r <= ain_value_nxt;
  end

  // Filter tick, one per 10 ms
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end
    else if (tick_cnt_r >= TICK_CYCLES - 1)
    begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  // First-order low-pass, time constant = setting in ticks
  always_comb
  begin
    int target;
    int diff;
    int step;
    target = int'($signed(ain_value_r)) <<< aios_pkg::FILT_FRAC;
    diff = target - int'(filt_acc_r);
    step = 0;
    filt_acc_nxt = filt_acc_r;
    if (ain_filter_tc_r == 16'h0000)
      filt_acc_nxt = target;
    else if (tick_r)
    begin
      step = diff / int'(ain_filter_tc_r);
      if (step == 0 && diff != 0)
        step = (diff > 0) ? 1 : -1;
      filt_acc_nxt = filt_acc_r + step;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      filt_acc_r <= '0;
    else
      filt_acc_r <= filt_acc_nxt;
  end

  assign filt_pct = 16'(filt_acc_r >>> aios_pkg::FILT_FRAC);

  // Frequency reference from filtered percent
  always_comb
  begin
    int mag;
    int fmin;
    int fmax;
    int f;
    f = 0;
    mag = (filt_pct < 0) ? -int'(filt_pct) : int'(filt_pct);
    fmin = int'(min_frequency_r);
    fmax = int'(max_frequency_r);
    if (dead_zone_sel_r[0])
    begin
      f = (fmax * mag) / aios_pkg::PCT_FULL;
      f = (f < fmin) ? fmin : f;
    end
    else
    begin
      f = fmin + ((fmax - fmin) * mag) / aios_pkg::PCT_FULL;
    end
    freq_ref_nxt = 16'(sat(f, fmin, fmax));
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      freq_ref_r <= 16'h0000;
      freq_reverse_r <= 1'b0;
      freq_ref_active_r <= 1'b0;
      ain_user_r <= 16'h0000;
    end
    else
    begin
      freq_ref_active_r <= (ain_function_r == aios_pkg::AIN_FN_FREQ_REF);
      if (ain_function_r == aios_pkg::AIN_FN_FREQ_REF)
      begin
        freq_ref_r <= freq_ref_nxt;
        freq_reverse_r <= filt_pct < 0;
      end
      else
      begin
        freq_ref_r <= 16'h0000;
        freq_reverse_r <= 1'b0;
      end
      ain_user_r <= (ain_function_r == aios_pkg::AIN_FN_USER) ? filt_pct : 16'h0000;
    end
  end

  // Output quantity select and gain
  always_comb
  begin
    int sel;
    sel = 0;
    unique case (aout_function_r)
      aios_pkg::AO_FN_SPEED_REF: sel = int'(src_speed_ref);
      aios_pkg::AO_FN_EFF_SPEED: sel = int'(src_eff_speed);
      aios_pkg::AO_FN_OUT_CURRENT: sel = int'(src_out_current);
      aios_pkg::AO_FN_ACT_CURRENT: sel = int'(src_act_current);
      aios_pkg::AO_FN_TORQUE: sel = int'(src_torque);
      aios_pkg::AO_FN_USER: sel = int'(src_user);
      aios_pkg::AO_FN_IXT: sel = int'(src_ixt);
      default: sel = 0;
    endcase
    sel = (sel * int'(aout_gain_r)) / aios_pkg::GAIN_UNIT;
    aout_level_nxt = 16'(sat(sel, 0, aios_pkg::PCT_FULL));
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      aout_level_r <= 16'h0000;
    else
      aout_level_r <= aout_level_nxt;
  end

  // Temperature reading
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      temp_reading_r <= aios_pkg::TEMP_SHORT_VAL;
    else if (open_sync_r[1])
      temp_reading_r <= aios_pkg::TEMP_OPEN_VAL;
    else if (short_sync_r[1])
      temp_reading_r <= aios_pkg::TEMP_SHORT_VAL;
    else
      temp_reading_r <= ({6'h00, temp_sample} > aios_pkg::TEMP_MAX_VAL) ?
        aios_pkg::TEMP_MAX_VAL : {6'h00, temp_sample};
  end

  // Avalon slave: one wait state, write lands when waitrequest is low
  assign wr_take = avs_write && !waitrequest_r;
  assign status = {12'h000, freq_reverse_r, short_sync_r[1], open_sync_r[1], sw_sync_r[1]};

  always_comb
  begin
    unique case (avs_address)
      aios_pkg::OFS_AIN_VALUE: rd_nxt = {{16{ain_value_r[15]}}, ain_value_r};
      aios_pkg::OFS_DEAD_ZONE_SEL: rd_nxt = {16'h0000, dead_zone_sel_r};
      aios_pkg::OFS_AIN_FUNCTION: rd_nxt = {16'h0000, ain_function_r};
      aios_pkg::OFS_AIN_GAIN: rd_nxt = {16'h0000, ain_gain_r};
      aios_pkg::OFS_AIN_SIGNAL_TYPE: rd_nxt = {16'h0000, ain_signal_type_r};
      aios_pkg::OFS_AIN_OFFSET: rd_nxt = {{16{ain_offset_r[15]}}, ain_offset_r};
      aios_pkg::OFS_AIN_FILTER_TC: rd_nxt = {16'h0000, ain_filter_tc_r};
      aios_pkg::OFS_TEMP_READING: rd_nxt = {16'h0000, temp_reading_r};
      aios_pkg::OFS_AOUT_VALUE: rd_nxt = {16'h0000, aout_level_r};
      aios_pkg::OFS_AOUT_FUNCTION: rd_nxt = {16'h0000, aout_function_r};
      aios_pkg::OFS_AOUT_GAIN: rd_nxt = {16'h0000, aout_gain_r};
      aios_pkg::OFS_MIN_FREQUENCY: rd_nxt = {16'h0000, min_frequency_r};
      aios_pkg::OFS_MAX_FREQUENCY: rd_nxt = {16'h0000, max_frequency_r};
      aios_pkg::OFS_FREQ_REF: rd_nxt = {16'h0000, freq_ref_r};
      aios_pkg::OFS_STATUS: rd_nxt = {16'h0000, status};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end
    else if ((avs_read || avs_write) && waitrequest_r)
    begin
      waitrequest_r <= 1'b0;
      readdata_r <= avs_read ? rd_nxt : 32'h0000_0000;
    end
    else
    begin
      waitrequest_r <= 1'b1;
    end
  end

  // Writes: input function, gain, offset, filter and output gain are clamped into range; other registers are masked or stored as written
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      dead_zone_sel_r <= aios_pkg::RST_DEAD_ZONE_SEL;
      ain_function_r <= aios_pkg::RST_AIN_FUNCTION;
      ain_gain_r <= aios_pkg::RST_AIN_GAIN;
      ain_signal_type_r <= aios_pkg::RST_AIN_SIGNAL_TYPE;
      ain_offset_r <= aios_pkg::RST_AIN_OFFSET;
      ain_filter_tc_r <= aios_pkg::RST_AIN_FILTER_TC;
      aout_function_r <= aios_pkg::RST_AOUT_FUNCTION;
      aout_gain_r <= aios_pkg::RST_AOUT_GAIN;
      min_frequency_r <= aios_pkg::RST_MIN_FREQUENCY;
      max_frequency_r <= aios_pkg::RST_MAX_FREQUENCY;
    end
    else if (wr_take)
    begin
      unique case (avs_address)
        aios_pkg::OFS_DEAD_ZONE_SEL: dead_zone_sel_r <= {15'h0000, avs_writedata[0]};
        aios_pkg::OFS_AIN_FUNCTION:
          ain_function_r <= (avs_writedata[15:0] > aios_pkg::AIN_FN_MAX) ?
            aios_pkg::AIN_FN_MAX : avs_writedata[15:0];
        aios_pkg::OFS_AIN_GAIN:
          ain_gain_r <= 16'(sat(int'(avs_writedata[15:0]), 0, aios_pkg::GAIN_MAX));
        aios_pkg::OFS_AIN_SIGNAL_TYPE: ain_signal_type_r <= {14'h0000, avs_writedata[1:0]};
        aios_pkg::OFS_AIN_OFFSET:
          ain_offset_r <= 16'(sat(int'($signed(avs_writedata[15:0])),
            -aios_pkg::PCT_FULL, aios_pkg::PCT_FULL));
        aios_pkg::OFS_AIN_FILTER_TC:
          ain_filter_tc_r <= 16'(sat(int'(avs_writedata[15:0]), 0,
            aios_pkg::FILT_TC_MAX));
        aios_pkg::OFS_AOUT_FUNCTION: aout_function_r <= avs_writedata[15:0];
        aios_pkg::OFS_AOUT_GAIN:
          aout_gain_r <= 16'(sat(int'(avs_writedata[15:0]), 0, aios_pkg::GAIN_MAX));
        aios_pkg::OFS_MIN_FREQUENCY: min_frequency_r <= avs_writedata[15:0];
        aios_pkg::OFS_MAX_FREQUENCY: max_frequency_r <= avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign freq_ref = freq_ref_r;
  assign freq_reverse = freq_reverse_r;
  assign freq_ref_active = freq_ref_active_r;
  assign ain_user = ain_user_r;
  assign aout_level = aout_level_r;

endmodule

// >>> dv/aios_checker.sv
`timescale 1ns/1ps
module aios_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] freq_ref,
  input wire logic freq_reverse,
  input wire logic freq_ref_active,
  input wire logic [15:0] ain_user,
  input wire logic [15:0] aout_level
);
  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_fn_off;
    !freq_ref_active [*4];
  endsequence
  a_wait_single: assert property (s_req |=> !avs_waitrequest)
    else $error("waitrequest stayed high after a request");
  a_wait_release: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ack_has_req: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data changed outside an answer");
  a_aout_range: assert property (aout_level <= 16'h03E8)
    else $error("output value above full scale");
  a_ref_off_zero: assert property (s_fn_off |-> freq_ref == 16'h0000)
    else $error("frequency reference while input not routed to it");
  a_user_off_zero: assert property (freq_ref_active [*3] |-> ain_user == 16'h0000)
    else $error("user value while input routed to frequency");
  a_rev_off_clear: assert property (s_fn_off |-> !freq_reverse)
    else $error("reverse set while input not routed to frequency");
endmodule
bind aios_top aios_checker i_chk (.mclk(mclk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .freq_ref(freq_ref), .freq_reverse(freq_reverse), .freq_ref_active(freq_ref_active),
  .ain_user(ain_user), .aout_level(aout_level));

// >>> dv/analog_io_scaling_tb.sv
`timescale 1ns/1ps
module analog_io_scaling_tb;
  logic mclk = 0;
  logic nrst = 0;
  logic [5:0] adr = 6'h00;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, r;
  logic wreq, frev, fact;
  logic [11:0] smp = 12'h000;
  logic smp_v = 0;
  logic sw = 0;
  logic n_open = 0;
  logic n_short = 0;
  logic [9:0] temp = 10'h000;
  logic [15:0] src [7];
  logic [15:0] fref, auser, alvl;
  int n_errors = 0;
  int num_checks = 0;
  int codes [7] = '{0, 2, 5, 7, 11, 12, 16};
  aios_top #(.TICK_CYCLES(4)) i_dut (.mclk(mclk), .nrst(nrst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(wreq), .ain_sample(smp), .ain_sample_valid(smp_v),
    .range_select_switch(sw), .temp_sample(temp), .ntc_open(n_open), .ntc_short(n_short),
    .src_speed_ref(src[0]), .src_eff_speed(src[1]), .src_out_current(src[2]),
    .src_act_current(src[3]), .src_torque(src[4]), .src_user(src[5]), .src_ixt(src[6]),
    .freq_ref(fref), .freq_reverse(frev), .freq_ref_active(fact), .ain_user(auser),
    .aout_level(alvl));
  initial
  begin
    for (int i = 0; i < 7; i++)
      src[i] = 16'(100 * (i + 1));
    forever #25 mclk = ~mclk;
  end
  task automatic give_verdict;
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (wreq !== 1'b0 && k < 50);
    if (k >= 50)
      chk(32'h0, 32'h1);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic feed(input logic [11:0] c);
    @(posedge mclk);
    smp <= c;
    smp_v <= 1'b1;
    @(posedge mclk);
    smp_v <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  function automatic int pct(input int c, t, s, off, g);
    int n, v;
    n = ((t % 2) == 1 && s != 0) ? (c - 819) * 1000 / 3276 : c * 1000 / 4095;
    v = (n + off) * g / 1000;
    if (t >= 2)
      v = 1000 - v;
    if (v > 1000)
      v = 1000;
    if (v < -1000)
      v = -1000;
    return v;
  endfunction
  function automatic int frq(input int p, dz);
    int a;
    a = p < 0 ? -p : p;
    if (dz != 0)
      return (600 * a / 1000 < 30) ? 30 : 600 * a / 1000;
    return 30 + 570 * a / 1000;
  endfunction
  task automatic ain_case(input int c, t, s, off, g, dz);
    int p;
    p = pct(c, t, s, off, g);
    sw <= (s != 0);
    wrr(aios_pkg::OFS_AIN_SIGNAL_TYPE, t);
    wrr(aios_pkg::OFS_AIN_OFFSET, off);
    wrr(aios_pkg::OFS_AIN_GAIN, g);
    wrr(aios_pkg::OFS_DEAD_ZONE_SEL, dz);
    feed(12'(c));
    rdc(aios_pkg::OFS_AIN_VALUE, p);
    chk(fref, frq(p, dz));
    rdc(aios_pkg::OFS_FREQ_REF, frq(p, dz));
    chk(frev, p < 0);
  endtask
  task automatic tmp(input int t, o, s, exp);
    temp <= 10'(t);
    n_open <= (o != 0);
    n_short <= (s != 0);
    repeat (5) @(posedge mclk);
    rdc(aios_pkg::OFS_TEMP_READING, exp);
  endtask
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rdc(aios_pkg::OFS_DEAD_ZONE_SEL, 0);
    rdc(aios_pkg::OFS_AIN_GAIN, 1000);
    rdc(aios_pkg::OFS_AIN_OFFSET, 0);
    rdc(aios_pkg::OFS_AIN_SIGNAL_TYPE, 0);
    rdc(aios_pkg::OFS_AIN_FUNCTION, 0);
    chk(fact, 1);
    chk(fref, 30);
    wrr(aios_pkg::OFS_AIN_GAIN, 10000);
    rdc(aios_pkg::OFS_AIN_GAIN, 9999);
    wrr(aios_pkg::OFS_AIN_OFFSET, -1200);
    rdc(aios_pkg::OFS_AIN_OFFSET, -1000);
    wrr(aios_pkg::OFS_AIN_FILTER_TC, 2000);
    rdc(aios_pkg::OFS_AIN_FILTER_TC, 1600);
    wrr(aios_pkg::OFS_AIN_FILTER_TC, 0);
    rdc(6'h3C, 0);
    rdc(6'h05, 0);
    ain_case(2048, 0, 0, -700, 1000, 0);
    ain_case(2457, 1, 1, -800, 1000, 0);
    ain_case(2457, 1, 0, 0, 1000, 1);
    ain_case(0, 2, 0, 0, 1000, 0);
    ain_case(819, 3, 1, 0, 1000, 1);
    ain_case(4095, 0, 0, 0, 9999, 0);
    ain_case(0, 0, 0, -1000, 2000, 1);
    ain_case(200, 0, 0, 0, 1000, 1);
    ain_case(200, 0, 0, 0, 1000, 0);
    ain_case(1000, 0, 0, 0, 0, 0);
    ain_case(2048, 0, 0, -700, 1000, 0);
    wrr(aios_pkg::OFS_AIN_FUNCTION, 7);
    feed(12'h800);
    chk(32'(signed'(auser)), -200);
    chk(fref, 0);
    chk(fact, 0);
    for (int f = 1; f < 7; f++)
    begin
      wrr(aios_pkg::OFS_AIN_FUNCTION, f);
      feed(12'h800);
      chk(auser, 0);
      chk(fact, 0);
    end
    wrr(aios_pkg::OFS_AIN_FUNCTION, 7);
    wrr(aios_pkg::OFS_AIN_OFFSET, 0);
    feed(12'h000);
    chk(auser, 0);
    wrr(aios_pkg::OFS_AIN_FILTER_TC, 10);
    feed(12'hFFF);
    rdc(aios_pkg::OFS_AIN_VALUE, 1000);
    repeat (25) @(posedge mclk);
    chk(auser >= 16'h01F4 && auser <= 16'h02F8, 1);
    repeat (240) @(posedge mclk);
    chk(auser >= 16'h03B6 && auser <= 16'h03E8, 1);
    tmp(55, 0, 0, 55);
    tmp(700, 0, 0, 100);
    tmp(55, 1, 0, 999);
    tmp(55, 0, 1, 0);
    tmp(55, 1, 1, 999);
    wrr(aios_pkg::OFS_TEMP_READING, 7);
    rdc(aios_pkg::OFS_TEMP_READING, 999);
    rdc(aios_pkg::OFS_STATUS, 6);
    for (int i = 0; i < 7; i++)
    begin
      wrr(aios_pkg::OFS_AOUT_FUNCTION, codes[i]);
      repeat (3) @(posedge mclk);
      chk(alvl, src[i]);
      rdc(aios_pkg::OFS_AOUT_VALUE, src[i]);
    end
    wrr(aios_pkg::OFS_AOUT_GAIN, 2000);
    rdc(aios_pkg::OFS_AOUT_VALUE, 1000);
    wrr(aios_pkg::OFS_AOUT_GAIN, 500);
    rdc(aios_pkg::OFS_AOUT_VALUE, 350);
    wrr(aios_pkg::OFS_AOUT_FUNCTION, 1);
    repeat (3) @(posedge mclk);
    chk(alvl, 0);
    give_verdict();
  end
endmodule
